// ===== dpt_pkg.sv
// Package: register map, field layout, reset values and divider counts for the dual prescaled down timer
package dpt_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] TIMER1_PRESCALER_VALUE_IDX = 8'hD2;
    localparam logic [7:0] TIMER1_COUNT_VALUE_IDX     = 8'hD3;
    localparam logic [7:0] TIMER1_CONTROL_STATUS_IDX  = 8'hD4;
    localparam logic [7:0] TIMER2_PRESCALER_VALUE_IDX = 8'hDA;
    localparam logic [7:0] TIMER2_COUNT_VALUE_IDX     = 8'hDB;
    localparam logic [7:0] TIMER2_CONTROL_STATUS_IDX  = 8'hDC;

    localparam int unsigned PADDR_WIDTH = 10;
    localparam int unsigned DATA_WIDTH  = 32;
    localparam int unsigned NUM_TIMERS  = 2;

    // ------------------------------------------------------------
    // Field positions of the control/status register
    // ------------------------------------------------------------
    localparam int unsigned CS_COUNT_ZERO_FLAG_BIT     = 7;
    localparam int unsigned CS_ZERO_IRQ_ENABLE_BIT     = 6;
    localparam int unsigned CS_SHARED_ENABLE_HIGH_BIT  = 5;
    localparam int unsigned CS_SHARED_ENABLE_LOW_BIT   = 4;
    localparam int unsigned CS_PRESCALER_RUN_BIT       = 3;
    localparam int unsigned CS_TAP_SELECT_LSB          = 0;

    // ------------------------------------------------------------
    // Reset values and counter compare constants
    // ------------------------------------------------------------
    localparam logic [6:0] PRESCALER_RESET = 7'h7F;
    localparam logic [7:0] COUNT_RESET     = 8'hFF;
    localparam logic [7:0] CONTROL_RESET   = 8'h00;
    localparam logic [7:0] COUNT_ZERO      = 8'h00;
    localparam logic [7:0] COUNT_ONE       = 8'h01;

    // ------------------------------------------------------------
    // Oscillator divide by 12 feeding the prescalers
    // ------------------------------------------------------------
    localparam int unsigned     OSC_DIVIDE   = 12;
    localparam logic [3:0]      OSC_DIV_LAST = 4'(OSC_DIVIDE - 1);

    typedef struct packed {
        logic       count_zero_flag;
        logic       zero_irq_enable;
        logic       shared_enable_high;
        logic       shared_enable_low;
        logic       prescaler_run;
        logic [2:0] tap_select;
    } dpt_ctrl_type;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  idx;
        logic [31:0] wdata;
    } dpt_access_type;

endpackage

// ===== dpt_timer.sv
// Dual prescaled 8-bit down timer with APB register access
//
// How it works
// - Each 8-bit counter decrements on selected prescaler edge; software loads and reads it.
// - Decrement to zero sets that timer's count-zero flag.
// - Flag and zero-irq enable both set raise that timer's interrupt request.
// - Any timer interrupt request also drives the core wake request.
// - The 7-bit prescaler counts down at pclk divided by 12.
// - Counter clock is the prescaler input or rising prescaler bit 0..6.
// - Three-bit tap select gives divide factor two to the power value.
// - Prescaler-run low holds prescaler at 7Fh and stops both counting.
// - Software loads the prescaler only while its prescaler-run bit is one.
// - Timers run only with first enable bit 4 one and bit 5 zero.
// - Second control register has no enable bits; they read zero.
// - Writing 00h to counter or one to control bit 7 sets flag.
// - Reset loads counters FFh, prescalers 7Fh, clears control registers.
// - Counter write beats a simultaneous decrement to zero; flag sets only if the write is 00h.
// - Counter and prescaler reads return live values at any time.
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps

module dpt_timer (
    input  wire logic                            pclk,
    input  wire logic                            presetn,
    input  wire logic                            psel,
    input  wire logic                            penable,
    input  wire logic                            pwrite,
    input  wire logic [dpt_pkg::PADDR_WIDTH-1:0] paddr,
    input  wire logic [dpt_pkg::DATA_WIDTH-1:0]  pwdata,
    input  wire logic [3:0]                      pstrb,
    output logic      [dpt_pkg::DATA_WIDTH-1:0]  prdata,
    output logic                                 pready,
    output logic                                 pslverr,
    output logic                                 timer1_irq,
    output logic                                 timer2_irq,
    output logic                                 wake_request
);
    import dpt_pkg::*;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    dpt_access_type acc;
    logic [NUM_TIMERS-1:0] hit;
    logic [7:0]            rd_byte [NUM_TIMERS];
    logic [7:0]            rd_sel;
    logic                  any_hit;
    logic                  word_aligned;
    logic                  setup_phase;

    assign word_aligned = (paddr[1:0] == 2'b00);
    assign setup_phase  = psel & ~penable;
    assign acc.idx      = paddr[PADDR_WIDTH-1:2];
    assign acc.wdata    = pwdata;
    // Writes take effect only at the completing access edge; low lane must be strobed
    assign acc.wr       = psel & penable & pwrite & any_hit & pstrb[0];
    assign acc.rd       = setup_phase & ~pwrite;
    assign any_hit      = word_aligned & (|hit);

    // Zero wait: read data is captured in the setup cycle so it comes from a flop
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~any_hit;

    assign rd_sel = hit[0] ? rd_byte[0] :
                    hit[1] ? rd_byte[1] :
                             8'h00;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (acc.rd) begin
            prdata <= {24'h00_0000, rd_sel};
        end
    end

    // ------------------------------------------------------------
    // Oscillator divider: one-cycle tick every twelve clocks
    // ------------------------------------------------------------
    logic [3:0] div_cnt;
    logic       osc_tick;

    assign osc_tick = (div_cnt == OSC_DIV_LAST);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt <= 4'h0;
        end else if (osc_tick) begin
            div_cnt <= 4'h0;
        end else begin
            div_cnt <= div_cnt + 4'h1;
        end
    end

    // ------------------------------------------------------------
    // Shared enable held in the first timer's control register
    // ------------------------------------------------------------
    dpt_ctrl_type ctl_view [NUM_TIMERS];
    logic [NUM_TIMERS-1:0] irq;
    logic                  timers_enabled;

    // Bit 5 set is reserved and treated as disabled
    assign timers_enabled = ctl_view[0].shared_enable_low & ~ctl_view[0].shared_enable_high;

    // ------------------------------------------------------------
    // Per-timer logic
    // ------------------------------------------------------------
    for (genvar t = 0; t < NUM_TIMERS; t++) begin : g_timer
        localparam logic [7:0] PRE_IDX = (t == 0) ? TIMER1_PRESCALER_VALUE_IDX : TIMER2_PRESCALER_VALUE_IDX;
        localparam logic [7:0] CNT_IDX = (t == 0) ? TIMER1_COUNT_VALUE_IDX     : TIMER2_COUNT_VALUE_IDX;
        localparam logic [7:0] CTL_IDX = (t == 0) ? TIMER1_CONTROL_STATUS_IDX  : TIMER2_CONTROL_STATUS_IDX;

        dpt_ctrl_type ctl;
        dpt_ctrl_type next_ctl;
        logic [6:0]   pre;
        logic [7:0]   cnt;
        logic [6:0]   pre_dec;
        logic [2:0]   tap_bit;
        logic         hit_pre;
        logic         hit_cnt;
        logic         hit_ctl;
        logic         wr_pre;
        logic         wr_cnt;
        logic         wr_ctl;
        logic         run;
        logic         step;
        logic         tap_edge;
        logic         cnt_step;
        logic         zero_event;
        logic         flag_set;

        assign hit_pre = word_aligned & (acc.idx == PRE_IDX);
        assign hit_cnt = word_aligned & (acc.idx == CNT_IDX);
        assign hit_ctl = word_aligned & (acc.idx == CTL_IDX);
        assign hit[t]  = hit_pre | hit_cnt | hit_ctl;

        assign wr_pre = acc.wr & hit_pre & ctl.prescaler_run;
        assign wr_cnt = acc.wr & hit_cnt;
        assign wr_ctl = acc.wr & hit_ctl;

        // Live values; prescaler bit 7 reads zero
        assign rd_byte[t] = hit_pre ? {1'b0, pre} :
                            hit_cnt ? cnt :
                            hit_ctl ? ctl :
                                      8'h00;

        assign run     = timers_enabled & ctl.prescaler_run;
        assign step    = run & osc_tick;
        assign pre_dec = pre - 7'h01;
        assign tap_bit = ctl.tap_select - 3'h1;

        // Counter clock is every prescaler step for tap 0, else the rising edge of the chosen prescaler bit
        assign tap_edge = (ctl.tap_select == 3'h0) ? 1'b1 : (~pre[tap_bit] & pre_dec[tap_bit]);
        assign cnt_step = step & tap_edge;

        // A simultaneous counter write suppresses the zero event
        assign zero_event = cnt_step & (cnt == COUNT_ONE) & ~wr_cnt;
        assign flag_set   = zero_event | (wr_cnt & (acc.wdata[7:0] == COUNT_ZERO));

        always_comb begin
            next_ctl = ctl;
            if (wr_ctl) begin
                next_ctl                 = dpt_ctrl_type'(acc.wdata[7:0]);
                next_ctl.shared_enable_high = (t == 0) ? acc.wdata[CS_SHARED_ENABLE_HIGH_BIT] : 1'b0;
                next_ctl.shared_enable_low  = (t == 0) ? acc.wdata[CS_SHARED_ENABLE_LOW_BIT]  : 1'b0;
            end
            // Hardware set wins over a software clear in the same cycle
            if (flag_set) begin
                next_ctl.count_zero_flag = 1'b1;
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                ctl <= dpt_ctrl_type'(CONTROL_RESET);
            end else begin
                ctl <= next_ctl;
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                pre <= PRESCALER_RESET;
            end else if (!ctl.prescaler_run) begin
                pre <= PRESCALER_RESET;
            end else if (wr_pre) begin
                pre <= acc.wdata[6:0];
            end else if (step) begin
                pre <= pre_dec;
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                cnt <= COUNT_RESET;
            end else if (wr_cnt) begin
                cnt <= acc.wdata[7:0];
            end else if (cnt_step) begin
                cnt <= cnt - 8'h01;
            end
        end

        assign ctl_view[t] = ctl;
        assign irq[t]      = ctl.count_zero_flag & ctl.zero_irq_enable;
    end

    // ------------------------------------------------------------
    // Interrupt requests and wake
    // ------------------------------------------------------------
    assign timer1_irq   = irq[0];
    assign timer2_irq   = irq[1];
    assign wake_request = |irq;

endmodule // dpt_timer

// ===== dpt_timer_properties.sv
// Checker: port-level relations of the dual prescaled down timer
`timescale 1ns/1ps
module dpt_timer_properties
    import dpt_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [9:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        timer1_irq,
    input wire logic        timer2_irq,
    input wire logic        wake_request
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire acc   = psel & penable & pready;
    wire wr_ok = acc & pwrite & pstrb[0];
    wire c1    = wr_ok & (paddr == {TIMER1_CONTROL_STATUS_IDX, 2'b00});
    wire c2    = wr_ok & (paddr == {TIMER2_CONTROL_STATUS_IDX, 2'b00});
    wire n1    = wr_ok & (paddr == {TIMER1_COUNT_VALUE_IDX, 2'b00});
    // ------------------------------------------------------------
    // Read data is captured at setup, so a read spans two cycles
    // ------------------------------------------------------------
    sequence s_rd(logic [7:0] i);
        psel & !penable & !pwrite & (paddr == {i, 2'b00}) ##1 acc;
    endsequence
    property p_wake; wake_request == (timer1_irq | timer2_irq); endproperty
    a_wake: assert property (p_wake) else $error("wake mismatch");
    property p_set1; c1 & pwdata[7] & pwdata[6] |=> timer1_irq; endproperty
    a_set1: assert property (p_set1) else $error("flag1 not set");
    property p_set2; c2 & pwdata[7] & pwdata[6] |=> timer2_irq; endproperty
    a_set2: assert property (p_set2) else $error("flag2 not set");
    property p_off1; c1 & !pwdata[6] |=> !timer1_irq; endproperty
    a_off1: assert property (p_off1) else $error("irq1 not masked");
    property p_hold1; timer1_irq & !c1 |=> timer1_irq; endproperty
    a_hold1: assert property (p_hold1) else $error("irq1 dropped alone");
    property p_stop; c1 & !pwdata[3] ##2 s_rd(TIMER1_PRESCALER_VALUE_IDX) |-> prdata[7:0] == 8'h7F; endproperty
    a_stop: assert property (p_stop) else $error("prescaler not pinned");
    property p_t2en; s_rd(TIMER2_CONTROL_STATUS_IDX) |-> prdata[5:4] == 2'b00; endproperty
    a_t2en: assert property (p_t2en) else $error("timer2 enable bits");
    property p_cnt;
        n1 ##2 s_rd(TIMER1_COUNT_VALUE_IDX) |-> prdata[7:0] inside {$past(pwdata[7:0], 3), $past(pwdata[7:0], 3) - 8'h01};
    endproperty
    a_cnt: assert property (p_cnt) else $error("count load lost");
endmodule // dpt_timer_properties

bind dpt_timer dpt_timer_properties dpt_timer_properties_inst (
    .pclk         (pclk),
    .presetn      (presetn),
    .psel         (psel),
    .penable      (penable),
    .pwrite       (pwrite),
    .paddr        (paddr),
    .pwdata       (pwdata),
    .pstrb        (pstrb),
    .prdata       (prdata),
    .pready       (pready),
    .timer1_irq   (timer1_irq),
    .timer2_irq   (timer2_irq),
    .wake_request (wake_request)
);

// ===== dpt_timer_tb_top.sv
// Self-checking bench for the dual prescaled down timer
`timescale 1ns/1ps
module dpt_timer_tb_top;
    import dpt_pkg::*;
    localparam logic [7:0] P1 = TIMER1_PRESCALER_VALUE_IDX;
    localparam logic [7:0] N1 = TIMER1_COUNT_VALUE_IDX;
    localparam logic [7:0] C1 = TIMER1_CONTROL_STATUS_IDX;
    localparam logic [7:0] C2 = TIMER2_CONTROL_STATUS_IDX;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [9:0]  paddr = 10'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  pstrb = 4'hF;
    logic [31:0] prdata;
    logic        pready, pslverr, timer1_irq, timer2_irq, wake_request, err;
    int          mismatches = 0;
    int          tests_run = 0;
    int          cycles = 0;
    logic [7:0]  map [6] = '{P1, N1, C1, TIMER2_PRESCALER_VALUE_IDX, TIMER2_COUNT_VALUE_IDX, C2};
    logic [7:0]  rst [6] = '{8'h7F, 8'hFF, 8'h00, 8'h7F, 8'hFF, 8'h00};
    always #10 pclk = ~pclk;
    dpt_timer dpt_timer_inst (
        .pclk         (pclk),
        .presetn      (presetn),
        .psel         (psel),
        .penable      (penable),
        .pwrite       (pwrite),
        .paddr        (paddr),
        .pwdata       (pwdata),
        .pstrb        (pstrb),
        .prdata       (prdata),
        .pready       (pready),
        .pslverr      (pslverr),
        .timer1_irq   (timer1_irq),
        .timer2_irq   (timer2_irq),
        .wake_request (wake_request)
    );
    // ------------------------------------------------------------
    // Bus tasks: request held until the edge that sees pready
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] i, input logic [7:0] d, output logic [31:0] r);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {i, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        logic [31:0] r;
        xfer(1'b1, i, d, r);
    endtask
    task automatic rd(input logic [7:0] i, input logic [7:0] e);
        logic [31:0] r;
        xfer(1'b0, i, 8'h00, r);
        chk(r, {24'h0, e});
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            test_done();
        end
    end
    initial begin
        logic [31:0] r;
        int k;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        foreach (map[i]) rd(map[i], rst[i]);
        xfer(1'b0, 8'h10, 8'h00, r);
        chk(32'(err), 32'h1);
        chk(r, 32'h0);
        $display("reset test done");
        wr(C1, 8'h10);
        rd(P1, 8'h7F);
        wr(P1, 8'h10);
        wr(N1, 8'h05);
        repeat (100) @(posedge pclk);
        rd(N1, 8'h05);
        rd(P1, 8'h7F);
        // Both the off and the reserved enable codes must keep the counter still
        for (int j = 0; j < 2; j++) begin
            wr(C1, j ? 8'h38 : 8'h08);
            wr(P1, 8'h10);
            wr(N1, 8'h05);
            repeat (100) @(posedge pclk);
            rd(N1, 8'h05);
            rd(P1, 8'h10);
        end
        wr(N1, 8'h00);
        rd(N1, 8'h00);
        rd(C1, 8'hB8);
        wr(C1, 8'h08);
        rd(C1, 8'h08);
        // A write with the low byte lane unstrobed must leave the counter alone
        pstrb <= 4'h0;
        wr(N1, 8'h33);
        pstrb <= 4'hF;
        rd(N1, 8'h00);
        wr(C2, 8'hF0);
        rd(C2, 8'hC0);
        chk(32'(timer2_irq), 32'h1);
        wr(C2, 8'h00);
        $display("stop and flag test done");
        for (int t = 0; t < 8; t++) begin
            wr(C1, 8'h08 | 8'(t));
            wr(P1, 8'h7F);
            wr(N1, 8'h02);
            wr(C1, 8'h58 | 8'(t));
            repeat (12 * (2 ** (t + 1) - 1) - 2) @(posedge pclk);
            chk(32'(timer1_irq), 32'h0);
            k = 0;
            while (timer1_irq !== 1'b1 && k < 30) begin
                @(posedge pclk);
                k++;
            end
            chk(32'(wake_request), 32'h1);
            rd(N1, 8'h00);
            rd(C1, 8'hD8 | 8'(t));
        end
        // Tap 7 keeps the next zero far away while the flag is set and cleared by software
        wr(C1, 8'hDF);
        @(posedge pclk);
        chk(32'(timer1_irq), 32'h1);
        wr(C1, 8'h5F);
        @(posedge pclk);
        chk(32'(timer1_irq), 32'h0);
        rd(C1, 8'h5F);
        $display("tap test done");
        test_done();
    end
endmodule // dpt_timer_tb_top
